// >>> hcie_ctrl.sv
`include "hcie_defs.svh"
// Event flags, enable mask and interrupt request of the host engine
module hcie_ctrl
  import hcie_pkg::*;
(
  input wire logic sys_clk_in,
  input wire logic rst_in,
  input wire logic ce_in,
  input wire logic cmd_valid_in,
  input wire hcie_cmd_type cmd_code_in,
  input wire hcie_word_type cmd_wdata_in,
  output hcie_word_type rdata_out,
  output logic rdata_valid_out,
  input wire logic root_hub_status_change_in,
  input wire logic [15:0] frame_number_in,
  input wire logic resume_signal_in,
  input wire logic resume_functional_state_in,
  input wire logic frame_start_in,
  input wire logic sched_overrun_in,
  output logic sof_out,
  output logic halt_out,
  output logic [1:0] overrun_count_out,
  output logic irq_out
);
  hcie_word_type event_flags_r;
  hcie_word_type event_flags_nxt;
  hcie_word_type event_enable_mask_r;
  hcie_word_type event_enable_mask_nxt;
  hcie_word_type rdata_r;
  hcie_word_type rd_mux;
  hcie_word_type set_vec;
  logic [1:0] overrun_cnt_r;
  logic sof_r;
  logic rvalid_r;
  logic [3:0] sync1_r;
  logic [3:0] sync2_r;
  logic [3:0] rise_w;
  logic [3:0] toggle_w;
  logic irq_w;
  logic wr_status;
  logic wr_enable;
  logic rd_hit;

  // Pins arrive from other logic domains: two-stage synchroniser first.
  // Keeps tracking through reset, so a pin resting high is no edge later.
  always_ff @(posedge sys_clk_in) begin
    if (rst_in || ce_in) begin
      sync1_r <= {frame_number_in[`HCIE_FRAME_MSB], resume_signal_in,
                  root_hub_status_change_in, resume_functional_state_in};
      sync2_r <= sync1_r;
    end
  end

  hcie_edge_detect #(.WIDTH(4)) u_edges (
    .sys_clk_in(sys_clk_in),
    .rst_in(rst_in),
    .ce_in(ce_in),
    .level_in(sync2_r),
    .rise_out(rise_w),
    .toggle_out(toggle_w)
  );

  // Read-code decode; unknown codes give no answer at all
  function automatic logic hcie_is_read(input hcie_cmd_type code);
    return (code == `HCIE_CMD_STATUS_RD) || (code == `HCIE_CMD_ENABLE_RD) ||
      (code == `HCIE_CMD_CMDST_RD);
  endfunction : hcie_is_read

  // Command decode
  assign wr_status = cmd_valid_in && (cmd_code_in == `HCIE_CMD_STATUS_WR);
  assign wr_enable = cmd_valid_in && (cmd_code_in == `HCIE_CMD_ENABLE_WR);
  assign rd_hit = cmd_valid_in && hcie_is_read(cmd_code_in);

  // Hardware set vector; system error never raised here
  always_comb begin
    set_vec = 32'h00000000;
    set_vec[`HCIE_BIT_ROOT_HUB_CHANGE_FLAG] = toggle_w[1];
    set_vec[`HCIE_BIT_FNO] = toggle_w[3];
    set_vec[`HCIE_BIT_UE] = 1'b0;
    // Software-entered resume masks the device edge
    set_vec[`HCIE_BIT_RD] = rise_w[2] && !sync2_r[0];
    set_vec[`HCIE_BIT_SF] = frame_start_in;
    set_vec[`HCIE_BIT_SO] = sched_overrun_in;
  end

  // Set wins over a simultaneous write-one clear
  assign event_flags_nxt = ((event_flags_r & ~(wr_status ? cmd_wdata_in : 32'h00000000))
                           | set_vec) & `HCIE_EVENT_MASK;
  // Set-only: no path here can clear an enable bit
  assign event_enable_mask_nxt = event_enable_mask_r
    | ((wr_enable ? cmd_wdata_in : 32'h00000000) & `HCIE_ENABLE_MASK);

  // Read select
  always_comb begin
    case (cmd_code_in)
      `HCIE_CMD_STATUS_RD: rd_mux = event_flags_r;
      `HCIE_CMD_ENABLE_RD: rd_mux = event_enable_mask_r;
      `HCIE_CMD_CMDST_RD: rd_mux = {14'h0000, overrun_cnt_r, 16'h0000};
      default: rd_mux = 32'h00000000;
    endcase
  end

  // State registers
  always_ff @(posedge sys_clk_in) begin
    if (rst_in) begin
      event_flags_r <= `HCIE_RESET_VAL;
      event_enable_mask_r <= `HCIE_RESET_VAL;
      overrun_cnt_r <= 2'h0;
      sof_r <= 1'b0;
      rdata_r <= 32'h00000000;
      rvalid_r <= 1'b0;
    end else if (ce_in) begin
      event_flags_r <= event_flags_nxt;
      event_enable_mask_r <= event_enable_mask_nxt;
      if (sched_overrun_in) begin
        overrun_cnt_r <= overrun_cnt_r + 2'h1;
      end
      sof_r <= frame_start_in;
      rvalid_r <= rd_hit;
      if (rd_hit) begin
        rdata_r <= rd_mux;
      end
    end
  end

  // Level request; any enabled flag with master enable
  assign irq_w = event_enable_mask_r[`HCIE_BIT_MIE] &&
                 |(event_flags_r & event_enable_mask_r & `HCIE_EVENT_MASK);
  assign irq_out = irq_w;
  // Flag is always zero, so the halt never asserts in this build
  assign halt_out = event_flags_r[`HCIE_BIT_UE];
  assign sof_out = sof_r;
  assign overrun_count_out = overrun_cnt_r;
  assign rdata_out = rdata_r;
  assign rdata_valid_out = rvalid_r;

  // Request gating: flag, its enable and the master enable all needed
  a_irq_gating: assert property (@(posedge sys_clk_in) disable iff (rst_in)
    irq_out |-> event_enable_mask_r[31] && |(event_flags_r & event_enable_mask_r))
    else $error("irq without enabled flag");
  a_irq_level: assert property (@(posedge sys_clk_in) disable iff (rst_in)
    (event_enable_mask_r[31] && |(event_flags_r & event_enable_mask_r & 32'h7d)) |-> irq_out)
    else $error("irq missing");
  a_mie_gate: assert property (@(posedge sys_clk_in) disable iff (rst_in)
    !event_enable_mask_r[31] |-> !irq_out)
    else $error("irq without master enable");

  // Event capture, one or more checks per flag source
  a_ue_zero: assert property (@(posedge sys_clk_in) disable iff (rst_in)
    !event_flags_r[4] && !halt_out)
    else $error("system error flag set");
  a_root_hub_change_flag_set: assert property (@(posedge sys_clk_in) disable iff (rst_in)
    (ce_in && toggle_w[1]) |=> event_flags_r[6])
    else $error("hub change not flagged");
  a_fno_set: assert property (@(posedge sys_clk_in) disable iff (rst_in)
    (ce_in && toggle_w[3]) |=> event_flags_r[5])
    else $error("frame overflow not flagged");
  a_resume_set: assert property (@(posedge sys_clk_in) disable iff (rst_in)
    (ce_in && rise_w[2] && !sync2_r[0]) |=> event_flags_r[3])
    else $error("resume not flagged");
  a_resume_masked: assert property (@(posedge sys_clk_in) disable iff (rst_in)
    (ce_in && sync2_r[0] && !event_flags_r[3]) |=> !event_flags_r[3])
    else $error("resume flagged in software resume");
  a_sf_set: assert property (@(posedge sys_clk_in) disable iff (rst_in)
    (ce_in && frame_start_in) |=> event_flags_r[2] && sof_out)
    else $error("frame start not flagged");
  a_sof_pulse: assert property (@(posedge sys_clk_in) disable iff (rst_in)
    (ce_in && !frame_start_in) |=> !sof_out)
    else $error("frame marker without frame start");
  a_so_count: assert property (@(posedge sys_clk_in) disable iff (rst_in)
    (ce_in && sched_overrun_in) |=> event_flags_r[0] &&
    overrun_cnt_r == $past(overrun_cnt_r) + 2'h1)
    else $error("overrun not counted");
  a_overrun_hold: assert property (@(posedge sys_clk_in) disable iff (rst_in)
    (ce_in && !sched_overrun_in) |=> overrun_cnt_r == $past(overrun_cnt_r))
    else $error("overrun count moved without overrun");

  // Enable mask: set-only; the guard skips the edge that leaves reset
  a_enable_sticky: assert property (@(posedge sys_clk_in) disable iff (rst_in)
    !$past(rst_in) |-> ((event_enable_mask_r & ~$past(event_enable_mask_r)) == 32'h0) ||
    $past(wr_enable && ce_in))
    else $error("enable grew without write");
  a_enable_hold: assert property (@(posedge sys_clk_in) disable iff (rst_in)
    !$past(rst_in) |->
    (event_enable_mask_r & $past(event_enable_mask_r)) == $past(event_enable_mask_r))
    else $error("enable bit cleared");
  a_enable_read: assert property (@(posedge sys_clk_in) disable iff (rst_in)
    (ce_in && cmd_valid_in && cmd_code_in == 8'h04) |=> rdata_valid_out &&
    rdata_out == $past(event_enable_mask_r))
    else $error("enable read wrong");

  // Status flags: write-one clear only, reserved bits stay zero
  a_flag_noclear: assert property (@(posedge sys_clk_in) disable iff (rst_in)
    (ce_in && !wr_status && event_flags_r[6]) |=> event_flags_r[6])
    else $error("flag cleared by hardware");
  a_flag_w1c: assert property (@(posedge sys_clk_in) disable iff (rst_in)
    (ce_in && wr_status && cmd_wdata_in[5] && !toggle_w[3]) |=> !event_flags_r[5])
    else $error("write one did not clear flag");
  a_flag_no_wset: assert property (@(posedge sys_clk_in) disable iff (rst_in)
    (ce_in && wr_status && !frame_start_in && !event_flags_r[2]) |=> !event_flags_r[2])
    else $error("status write set a flag");
  a_reserved_zero: assert property (@(posedge sys_clk_in) disable iff (rst_in)
    (event_flags_r & ~32'h0000007d) == 32'h0 &&
    (event_enable_mask_r & ~32'h8000007d) == 32'h0)
    else $error("reserved bit set");
  a_status_read: assert property (@(posedge sys_clk_in) disable iff (rst_in)
    (ce_in && cmd_valid_in && cmd_code_in == 8'h03) |=> rdata_valid_out &&
    rdata_out == $past(event_flags_r))
    else $error("status read wrong");
  a_cmdst_read: assert property (@(posedge sys_clk_in) disable iff (rst_in)
    (ce_in && cmd_valid_in && cmd_code_in == 8'h02) |=> rdata_valid_out &&
    rdata_out == {14'h0000, $past(overrun_cnt_r), 16'h0000})
    else $error("overrun count read wrong");
  a_bad_code: assert property (@(posedge sys_clk_in) disable iff (rst_in)
    (ce_in && !(cmd_valid_in && cmd_code_in inside {8'h02, 8'h03, 8'h04})) |=> !rdata_valid_out)
    else $error("answer to unknown command");
  a_state_freeze: assert property (@(posedge sys_clk_in) disable iff (rst_in)
    !ce_in |=> $stable(event_flags_r) && $stable(event_enable_mask_r) &&
    $stable(overrun_cnt_r))
    else $error("state moved while frozen");
endmodule : hcie_ctrl

// >>> hcie_defs.svh
`ifndef HCIE_DEFS_SVH
`define HCIE_DEFS_SVH
// Behaviour
// - Set root hub change flag when root hub or any port status changes.
// - Set frame overflow flag on every toggle of frame number bit 15.
// - System error flag at bit 4 always reads zero here.
// - A flagged system error halts processing and bus signalling until corrected.
// - Set resume detected flag on rising edge of device resume signalling.
// - No resume flag when software itself enters the resume functional state.
// - At each frame start set frame start flag and emit an SOF.
// - Schedule overrun sets overrun flag and increments the overrun counter.
// - Each enable bit gates the status flag at the same position.
// - Interrupt requested only when flag, its enable and master enable set.
// - Enable register writes set ones; zeros leave bits unchanged.
// - Enable register read returns current contents including master enable.
// - Enable register read code 04h, write code 84h.
// - Status flags cleared only by software writing one; hardware never clears.
// - Status register read code 03h, write code 83h.
// - Two-bit overrun counter starts zero, counts every overrun, wraps.
`define HCIE_CMD_STATUS_RD 8'h03
`define HCIE_CMD_STATUS_WR 8'h83
`define HCIE_CMD_ENABLE_RD 8'h04
`define HCIE_CMD_ENABLE_WR 8'h84
`define HCIE_CMD_CMDST_RD 8'h02
`define HCIE_BIT_SO 0
`define HCIE_BIT_SF 2
`define HCIE_BIT_RD 3
`define HCIE_BIT_UE 4
`define HCIE_BIT_FNO 5
`define HCIE_BIT_ROOT_HUB_CHANGE_FLAG 6
`define HCIE_BIT_MIE 31
`define HCIE_FRAME_MSB 15
`define HCIE_CNT_LSB 16
`define HCIE_EVENT_MASK 32'h0000007d
`define HCIE_ENABLE_MASK 32'h8000007d
`define HCIE_RESET_VAL 32'h00000000
`endif

// >>> hcie_edge_detect.sv
// Registered edge detector for the event inputs
module hcie_edge_detect #(
  parameter int WIDTH = 4
) (
  input wire logic sys_clk_in,
  input wire logic rst_in,
  input wire logic ce_in,
  input wire logic [WIDTH-1:0] level_in,
  output logic [WIDTH-1:0] rise_out,
  output logic [WIDTH-1:0] toggle_out
);
  logic [WIDTH-1:0] prev_r;
  // Previous value, frozen with the clock enable
  always_ff @(posedge sys_clk_in) begin
    if (rst_in) begin
      prev_r <= level_in; // Tracks the level through reset: no false edge at release
    end else if (ce_in) begin
      prev_r <= level_in;
    end
  end
  assign rise_out = level_in & ~prev_r;
  assign toggle_out = level_in ^ prev_r;
endmodule : hcie_edge_detect

// >>> hcie_host_model.sv
// Host processor issuing register commands
module hcie_host_model
  import hcie_pkg::*;
(
  input wire logic sys_clk_in,
  output logic cmd_valid_out,
  output hcie_cmd_type cmd_code_out,
  output hcie_word_type cmd_wdata_out,
  input wire hcie_word_type rdata_in,
  input wire logic rdata_valid_in
);
  timeunit 1ns;
  timeprecision 1ns;
  initial begin
    cmd_valid_out = 1'b0;
    cmd_code_out = 8'h00;
    cmd_wdata_out = 32'h0;
  end
  // One command per call; valid drops after one clock cycle
  task automatic access(input hcie_cmd_type c, input hcie_word_type w,
      output hcie_word_type rd, output logic ok);
    @(negedge sys_clk_in);
    cmd_valid_out = 1'b1;
    cmd_code_out = c;
    cmd_wdata_out = w;
    @(negedge sys_clk_in);
    ok = rdata_valid_in;
    rd = rdata_in;
    cmd_valid_out = 1'b0;
    // Released lines never keep the last value
    cmd_code_out = ~c;
    cmd_wdata_out = ~w;
  endtask : access
endmodule : hcie_host_model

// >>> hcie_pkg.sv
package hcie_pkg;
  typedef logic [31:0] hcie_word_type;
  typedef logic [7:0] hcie_cmd_type;
endpackage : hcie_pkg

// >>> host_ctrl_interrupt_status_enable_bench.sv
module host_ctrl_interrupt_status_enable_bench;
  import hcie_pkg::*;
  timeunit 1ns;
  timeprecision 1ns;
  logic sys_clk_in = 1'b0;
  logic rst_in = 1'b1;
  logic hub = 1'b0;
  logic [15:0] frame = 16'h0;
  logic res = 1'b0;
  logic res_fs = 1'b0;
  logic fs = 1'b0;
  logic ovr = 1'b0;
  logic ce = 1'b1;
  logic cmd_valid, rdata_valid, sof, halt, irq, ok;
  hcie_cmd_type code;
  hcie_word_type wdata, rdata, d, en, w;
  logic [1:0] cnt;
  int num_errors = 0;
  int checks = 0;
  int seed = 31;
  always #5 sys_clk_in = ~sys_clk_in;
  hcie_ctrl u_hcie_ctrl (.sys_clk_in(sys_clk_in), .rst_in(rst_in), .ce_in(ce),
    .cmd_valid_in(cmd_valid), .cmd_code_in(code), .cmd_wdata_in(wdata), .rdata_out(rdata),
    .rdata_valid_out(rdata_valid), .root_hub_status_change_in(hub), .frame_number_in(frame),
    .resume_signal_in(res), .resume_functional_state_in(res_fs), .frame_start_in(fs),
    .sched_overrun_in(ovr), .sof_out(sof), .halt_out(halt), .overrun_count_out(cnt),
    .irq_out(irq));
  hcie_host_model u_hcie_host_model (.sys_clk_in(sys_clk_in), .cmd_valid_out(cmd_valid),
    .cmd_code_out(code), .cmd_wdata_out(wdata), .rdata_in(rdata), .rdata_valid_in(rdata_valid));
  task automatic check(input hcie_word_type seen, input hcie_word_type exp);
    checks++;
    if (seen !== exp) begin
      num_errors++;
      $display("MISMATCH %0t seen %h expected %h", $time, seen, exp);
    end
  endtask : check
  task automatic rd(input hcie_cmd_type c, input hcie_word_type exp);
    u_hcie_host_model.access(c, 32'h0, d, ok);
    check({31'h0, ok}, 32'h1);
    check(d, exp);
  endtask : rd
  task automatic wr(input hcie_cmd_type c, input hcie_word_type v);
    u_hcie_host_model.access(c, v, d, ok);
  endtask : wr
  // Level request: a set flag, its enable and the master enable
  function automatic logic exp_irq(input hcie_word_type fl, input hcie_word_type e);
    return e[31] && ((fl & e & 32'h7d) != 32'h0);
  endfunction : exp_irq
  task automatic conclude();
    $display("checks %0d mismatches %0d", checks, num_errors);
    if (num_errors == 0 && checks > 0)
      $display("TB: PASS");
    else
      $display("TB: FAIL");
    $finish;
  endtask : conclude
  // Sequence: reset values, events, gating, random enable writes
  initial begin
    repeat (20) @(negedge sys_clk_in);
    rst_in = 1'b0;
    rd(8'h03, 32'h0);
    rd(8'h04, 32'h0);
    rd(8'h02, 32'h0);
    $display("test reset done");
    @(negedge sys_clk_in) fs = 1'b1;
    ovr = 1'b1;
    @(negedge sys_clk_in) fs = 1'b0;
    check({31'h0, sof}, 32'h1);
    repeat (4) @(negedge sys_clk_in);
    ovr = 1'b0;
    @(negedge sys_clk_in);
    check({30'h0, cnt}, 32'h1);
    rd(8'h02, 32'h00010000);
    res_fs = 1'b1;
    res = 1'b1;
    repeat (6) @(negedge sys_clk_in);
    rd(8'h03, 32'h5);
    res = 1'b0;
    repeat (6) @(negedge sys_clk_in);
    res_fs = 1'b0;
    hub = 1'b1;
    frame = 16'h8000;
    res = 1'b1;
    repeat (6) @(negedge sys_clk_in);
    rd(8'h03, 32'h6d);
    check({31'h0, halt}, 32'h0);
    wr(8'h83, 32'h20);
    frame = 16'h7fff;
    repeat (6) @(negedge sys_clk_in);
    wr(8'h83, 32'h0);
    rd(8'h03, 32'h6d);
    $display("test events done");
    check({31'h0, irq}, 32'h0);
    wr(8'h84, 32'h4);
    check({31'h0, irq}, 32'h0);
    wr(8'h84, 32'h80000000);
    check({31'h0, irq}, 32'h1);
    rd(8'h04, 32'h80000004);
    wr(8'h83, 32'h4);
    check({31'h0, irq}, 32'h0);
    rd(8'h03, 32'h69);
    u_hcie_host_model.access(8'h55, 32'hffffffff, d, ok);
    check({31'h0, ok}, 32'h0);
    en = 32'h80000004;
    for (int i = 0; i < 8; i++) begin
      w = $random(seed);
      wr(8'h84, w);
      en = en | (w & 32'h8000007d);
      rd(8'h04, en);
      check({31'h0, irq}, {31'h0, exp_irq(32'h69, en)});
    end
    $display("test enables done");
    // Frozen clock enable: events and overruns must leave no trace
    @(negedge sys_clk_in) ce = 1'b0;
    fs = 1'b1;
    ovr = 1'b1;
    repeat (3) @(negedge sys_clk_in);
    fs = 1'b0;
    ovr = 1'b0;
    ce = 1'b1;
    check({31'h0, sof}, 32'h0);
    rd(8'h02, 32'h00010000);
    wr(8'h83, 32'hffffff82);
    rd(8'h03, 32'h69);
    $display("test freeze done");
    // Mid-run reset while the hub and resume signal pins rest away from their first levels
    @(negedge sys_clk_in) rst_in = 1'b1;
    repeat (2) @(negedge sys_clk_in);
    rst_in = 1'b0;
    rd(8'h03, 32'h0);
    rd(8'h04, 32'h0);
    rd(8'h02, 32'h0);
    check({31'h0, irq}, 32'h0);
    $display("test second reset done");
    conclude();
  end
  // Watchdog well past the expected run length
  initial begin
    repeat (3000) @(posedge sys_clk_in);
    num_errors++;
    conclude();
  end
endmodule : host_ctrl_interrupt_status_enable_bench
